/* rtl/compare_unit_map.vh */
`ifndef COMPARE_UNIT_MAP_VH
`define COMPARE_UNIT_MAP_VH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_FORCE 8'h08
`define OFS_CMP_LOW 8'h0C
`define OFS_CMP_HIGH 8'h10

// control fields
`define CTL_WGM_LSB 0
`define CTL_WGM_MSB 3
`define CTL_COM_LSB 4
`define CTL_COM_MSB 5
`define CTL_IRQ_EN 6

// status fields
`define STS_FLAG 0
`define STS_OUT 1

// force field
`define FRC_STROBE 0

// reset values
`define RST_WGM 4'h0
`define RST_COM 2'h0
`define RST_CMP 16'h0000
`define RST_WORD 32'h00000000

// compare output mode codes
`define COM_NONE 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

// waveform modes of note
`define WGM_NORMAL 4'h0
`define WGM_PC8 4'h1
`define WGM_PC9 4'h2
`define WGM_PC10 4'h3
`define WGM_CTC_A 4'h4
`define WGM_FAST8 4'h5
`define WGM_FAST9 4'h6
`define WGM_FAST10 4'h7
`define WGM_PFC_ICR 4'h8
`define WGM_PFC_A 4'h9
`define WGM_PC_ICR 4'hA
`define WGM_PC_A 4'hB
`define WGM_CTC_ICR 4'hC
`define WGM_RESERVED 4'hD
`define WGM_FAST_ICR 4'hE
`define WGM_FAST_A 4'hF

// masks for fixed-top modes
`define MASK_8BIT 16'h00FF
`define MASK_9BIT 16'h01FF
`define MASK_10BIT 16'h03FF
`define MASK_FULL 16'hFFFF

`endif

/* rtl/timer_output_compare_unit.v */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "compare_unit_map.vh"

module timer_output_compare_unit (
   // clock and reset
   input wire clock,
   input wire rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // counter side
   input wire [15:0] running_count,
   input wire timer_tick,
   input wire count_top,
   input wire count_bottom,
   input wire count_down,
   input wire count_write,
   output reg [15:0] top_value,
   // interrupt
   input wire irq_serviced,
   output reg irq_request,
   // port pin
   input wire port_value,
   input wire pin_direction_bit,
   output reg pin_out,
   output reg pin_out_enable
);

   reg [3:0] waveform_mode_sel;
   reg [1:0] compare_output_mode;
   reg compare_irq_enable;
   reg compare_match_flag;
   reg channel_output_state;
   reg [15:0] compare_value;
   reg [15:0] compare_buffer;
   reg [7:0] high_hold;
   reg block_next_tick;
   reg match_seen;

   wire access_ok;
   wire write_now;
   wire mapped;
   wire match_eq;
   wire is_pwm;
   wire is_fast;
   wire load_at_bottom;
   wire transfer_now;
   wire force_now;
   wire [15:0] cmp_written;
   reg [15:0] fixed_mask;
   reg next_ocs;
   reg [31:0] next_rdata;

   assign mapped = (paddr == `OFS_CONTROL) || (paddr == `OFS_STATUS) ||
                   (paddr == `OFS_FORCE) || (paddr == `OFS_CMP_LOW) ||
                   (paddr == `OFS_CMP_HIGH);
   assign access_ok = psel & penable & pready;
   assign write_now = access_ok & pwrite & mapped;

   // normal, both clear-on-match modes and the reserved code are the only unbuffered ones
   assign is_pwm = (waveform_mode_sel != `WGM_NORMAL) &&
                   (waveform_mode_sel != `WGM_CTC_A) &&
                   (waveform_mode_sel != `WGM_CTC_ICR) &&
                   (waveform_mode_sel != `WGM_RESERVED);
   assign is_fast = (waveform_mode_sel == `WGM_FAST8) || (waveform_mode_sel == `WGM_FAST9) ||
                    (waveform_mode_sel == `WGM_FAST10) ||
                    (waveform_mode_sel == `WGM_FAST_ICR) ||
                    (waveform_mode_sel == `WGM_FAST_A);
   // phase and frequency correct reloads at bottom, the rest at top
   assign load_at_bottom = (waveform_mode_sel == `WGM_PFC_ICR) ||
                           (waveform_mode_sel == `WGM_PFC_A);
   assign transfer_now = is_pwm & timer_tick &
                         (load_at_bottom ? count_bottom : count_top);

   assign match_eq = (running_count == compare_value);
   assign force_now = write_now & (paddr == `OFS_FORCE) & pwdata[`FRC_STROBE] & ~is_pwm;

   // fixed-top modes drop the unused high bits on write
   always @* begin
      case (waveform_mode_sel)
         `WGM_PC8, `WGM_FAST8: fixed_mask = `MASK_8BIT;
         `WGM_PC9, `WGM_FAST9: fixed_mask = `MASK_9BIT;
         `WGM_PC10, `WGM_FAST10: fixed_mask = `MASK_10BIT;
         default: fixed_mask = `MASK_FULL;
      endcase
   end

   assign cmp_written = {high_hold, pwdata[7:0]} & fixed_mask;

   // waveform action on a real or forced match or a fast-mode top, mode bits read live
   always @* begin
      next_ocs = channel_output_state;
      if (force_now) begin
         case (compare_output_mode)
            `COM_TOGGLE: next_ocs = ~channel_output_state;
            `COM_CLEAR: next_ocs = 1'b0;
            `COM_SET: next_ocs = 1'b1;
            default: next_ocs = channel_output_state;
         endcase
      end else if (timer_tick) begin
         if (!is_pwm) begin
            if (match_seen) begin
               case (compare_output_mode)
                  `COM_TOGGLE: next_ocs = ~channel_output_state;
                  `COM_CLEAR: next_ocs = 1'b0;
                  `COM_SET: next_ocs = 1'b1;
                  default: next_ocs = channel_output_state;
               endcase
            end
         end else if (is_fast) begin
            if (compare_output_mode == `COM_TOGGLE) begin
               if (match_seen && waveform_mode_sel == `WGM_FAST_A) begin
                  next_ocs = ~channel_output_state;
               end
            end else if (compare_output_mode != `COM_NONE) begin
               // top wins over a match landing on the same tick
               if (count_top) begin
                  next_ocs = (compare_output_mode == `COM_SET);
               end else if (match_seen) begin
                  next_ocs = (compare_output_mode == `COM_CLEAR);
               end
            end
         end else begin
            if (compare_output_mode == `COM_TOGGLE) begin
               if (match_seen && (waveform_mode_sel == `WGM_PFC_A ||
                                  waveform_mode_sel == `WGM_PC_A)) begin
                  next_ocs = ~channel_output_state;
               end
            end else if (compare_output_mode != `COM_NONE && match_seen) begin
               // dual slope: up-count match and down-count match act oppositely
               next_ocs = (compare_output_mode == `COM_CLEAR) ? count_down : ~count_down;
            end
         end
      end
   end

   // read mux; compare bytes come straight from storage
   always @* begin
      next_rdata = `RST_WORD;
      case (paddr)
         `OFS_CONTROL: begin
            next_rdata[`CTL_WGM_MSB:`CTL_WGM_LSB] = waveform_mode_sel;
            next_rdata[`CTL_COM_MSB:`CTL_COM_LSB] = compare_output_mode;
            next_rdata[`CTL_IRQ_EN] = compare_irq_enable;
         end
         `OFS_STATUS: begin
            next_rdata[`STS_FLAG] = compare_match_flag;
            next_rdata[`STS_OUT] = channel_output_state;
         end
         `OFS_CMP_LOW: begin
            next_rdata[7:0] = is_pwm ? compare_buffer[7:0] : compare_value[7:0];
         end
         `OFS_CMP_HIGH: begin
            next_rdata[7:0] = is_pwm ? compare_buffer[15:8] : compare_value[15:8];
         end
         default: next_rdata = `RST_WORD;
      endcase
   end

   // apb: no wait states, answer registered during setup
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `RST_WORD;
      end else begin
         pready <= psel & ~penable;
         if (psel & ~penable) begin
            pslverr <= ~mapped;
            prdata <= pwrite ? `RST_WORD : next_rdata;
         end else begin
            pslverr <= 1'b0;
            prdata <= `RST_WORD;
         end
      end
   end

   // control register and the shared high-byte holding register
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         waveform_mode_sel <= `RST_WGM;
         compare_output_mode <= `RST_COM;
         compare_irq_enable <= 1'b0;
         high_hold <= 8'h00;
      end else if (write_now) begin
         if (paddr == `OFS_CONTROL) begin
            waveform_mode_sel <= pwdata[`CTL_WGM_MSB:`CTL_WGM_LSB];
            compare_output_mode <= pwdata[`CTL_COM_MSB:`CTL_COM_LSB];
            compare_irq_enable <= pwdata[`CTL_IRQ_EN];
         end
         if (paddr == `OFS_CMP_HIGH) begin
            high_hold <= pwdata[7:0];
         end
      end
   end

   // compare storage: only software writes and the buffer transfer touch it
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         compare_value <= `RST_CMP;
         compare_buffer <= `RST_CMP;
      end else begin
         if (write_now && paddr == `OFS_CMP_LOW) begin
            if (is_pwm) begin
               compare_buffer <= cmp_written;
            end else begin
               compare_value <= cmp_written;
            end
         end else if (transfer_now) begin
            compare_value <= compare_buffer;
         end
      end
   end

   // match pipeline and suppression after a counter write
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         block_next_tick <= 1'b0;
         match_seen <= 1'b0;
      end else begin
         if (count_write) begin
            block_next_tick <= 1'b1;
         end else if (timer_tick) begin
            block_next_tick <= 1'b0;
         end
         if (timer_tick) begin
            match_seen <= match_eq & ~block_next_tick & ~count_write;
         end
      end
   end

   // flag: hardware set beats any clear in the same cycle
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         compare_match_flag <= 1'b0;
      end else if (timer_tick && match_seen) begin
         compare_match_flag <= 1'b1;
      end else if (write_now && paddr == `OFS_STATUS && pwdata[`STS_FLAG]) begin
         compare_match_flag <= 1'b0;
      end else if (irq_serviced && compare_irq_enable) begin
         compare_match_flag <= 1'b0;
      end
   end

   // output state is never touched by a mode change itself
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         channel_output_state <= 1'b0;
      end else begin
         channel_output_state <= next_ocs;
      end
   end

   // registered outputs toward the counter, interrupt line and pin
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         top_value <= `RST_CMP;
         irq_request <= 1'b0;
         pin_out <= 1'b0;
         pin_out_enable <= 1'b0;
      end else begin
         top_value <= compare_value;
         irq_request <= compare_match_flag & compare_irq_enable;
         pin_out <= (compare_output_mode != `COM_NONE) ? channel_output_state
                                                        : port_value;
         pin_out_enable <= pin_direction_bit;
      end
   end

endmodule // timer_output_compare_unit

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "compare_unit_map.vh"
module tb_top;
   logic clock, rst, psel, penable, pwrite, timer_tick, count_write, irq_serviced;
   logic count_top, count_bottom, count_down, port_value, pin_direction_bit, slv;
   logic [7:0] paddr;
   logic [31:0] pwdata, rd_data;
   logic [15:0] running_count;
   wire [31:0] prdata;
   wire [15:0] top_value;
   wire pready, pslverr, irq_request, pin_out, pin_out_enable;
   int err_total, n_checks;
   timer_output_compare_unit u_timer_output_compare_unit (.clock(clock), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .running_count(running_count),
      .timer_tick(timer_tick), .count_top(count_top), .count_bottom(count_bottom),
      .count_down(count_down), .count_write(count_write), .top_value(top_value),
      .irq_serviced(irq_serviced), .irq_request(irq_request), .port_value(port_value),
      .pin_direction_bit(pin_direction_bit), .pin_out(pin_out), .pin_out_enable(pin_out_enable));
   initial begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // held until pready; released one edge before the next setup may start
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) chk("pready", 1, 0);
      rd_data = prdata;
      slv = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(0, a, 32'h00000000);
      chk(nm, e, rd_data);
   endtask
   task automatic cnt(input logic [15:0] c);
      running_count <= c;
      timer_tick <= 1;
      @(posedge clock);
      timer_tick <= 0;
      repeat (2) @(posedge clock);
   endtask
   task automatic t_reset;
      rd(`OFS_STATUS, 0, "status");
      chk("pin_out", 0, pin_out);
      $display("reset test done");
   endtask
   task automatic t_cmp;
      wr(`OFS_CMP_HIGH, 32'h12);
      rd(`OFS_CMP_HIGH, 0, "high held");
      wr(`OFS_CMP_LOW, 32'h34);
      rd(`OFS_CMP_LOW, 32'h34, "low");
      rd(`OFS_CMP_HIGH, 32'h12, "high");
      chk("top", 32'h1234, top_value);
      $display("compare write test done");
   endtask
   task automatic t_flag;
      wr(`OFS_CONTROL, 32'h40);
      cnt(16'h1234);
      rd(`OFS_STATUS, 0, "flag early");
      cnt(16'h1234);
      rd(`OFS_STATUS, 1, "flag");
      chk("irq", 1, irq_request);
      wr(`OFS_STATUS, 0);
      rd(`OFS_STATUS, 1, "flag kept");
      irq_serviced <= 1;
      @(posedge clock);
      irq_serviced <= 0;
      rd(`OFS_STATUS, 0, "flag serviced");
      chk("irq off", 0, irq_request);
      cnt(16'h0000);
      wr(`OFS_STATUS, 1);
      rd(`OFS_STATUS, 0, "flag cleared");
      $display("flag test done");
   endtask
   task automatic t_pwm;
      wr(`OFS_CONTROL, 32'h2F);
      wr(`OFS_CMP_HIGH, 32'h00);
      wr(`OFS_CMP_LOW, 32'h56);
      rd(`OFS_CMP_LOW, 32'h56, "buffer");
      chk("top held", 32'h1234, top_value);
      count_top <= 1;
      cnt(16'h0000);
      count_top <= 0;
      chk("top moved", 32'h56, top_value);
      rd(`OFS_STATUS, 1, "pwm top");
      wr(`OFS_CONTROL, 32'h3F);
      wr(`OFS_FORCE, 1);
      rd(`OFS_STATUS, 1, "force ignored");
      $display("pwm test done");
   endtask
   task automatic t_block;
      // counter written to a plain value, never to top or bottom
      running_count <= 16'h1234;
      count_write <= 1;
      @(posedge clock);
      count_write <= 0;
      cnt(16'h1234);
      cnt(16'h0000);
      rd(`OFS_STATUS, 0, "blocked");
      $display("block test done");
   endtask
   task automatic t_force;
      wr(`OFS_CONTROL, 32'h30);
      wr(`OFS_FORCE, 1);
      pin_direction_bit <= 1;
      rd(`OFS_STATUS, 2, "forced");
      chk("pin forced", 1, pin_out);
      chk("pin enable", 1, pin_out_enable);
      wr(`OFS_CONTROL, 32'h04);
      rd(`OFS_STATUS, 2, "state kept");
      chk("pin port", 0, pin_out);
      $display("force test done");
   endtask
   task automatic t_ctc;
      wr(`OFS_CONTROL, 32'h14);
      cnt(16'h1234);
      cnt(16'h0000);
      rd(`OFS_STATUS, 1, "toggle low");
      chk("pin low", 0, pin_out);
      cnt(16'h1234);
      cnt(16'h0000);
      rd(`OFS_STATUS, 3, "toggle high");
      wr(`OFS_CONTROL, 32'h04);
      cnt(16'h1234);
      cnt(16'h0000);
      rd(`OFS_STATUS, 3, "no action");
      $display("toggle test done");
   endtask
   task automatic t_bad;
      rd(8'h20, 0, "unmapped data");
      chk("pslverr", 1, slv);
      $display("unmapped test done");
   endtask
   initial begin
      rst = 1;
      {psel, penable, pwrite, timer_tick, count_write, irq_serviced} = 0;
      {count_top, count_bottom, count_down, port_value, pin_direction_bit} = 0;
      paddr = 0;
      pwdata = 0;
      running_count = 0;
      repeat (3) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      t_reset;
      t_cmp;
      t_flag;
      t_block;
      t_force;
      t_ctc;
      t_pwm;
      t_bad;
      end_sim;
   end
   initial begin
      #(50 * 5000);
      err_total++;
      end_sim;
   end
endmodule // tb_top
`default_nettype wire

/* test/timer_output_compare_unit_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module compare_unit_chk (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // timer and pin
   input wire logic timer_tick,
   input wire logic irq_serviced,
   input wire logic irq_request,
   input wire logic pin_direction_bit,
   input wire logic pin_out,
   input wire logic pin_out_enable
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_setup; psel && !penable; endsequence
   sequence s_svc; irq_serviced && irq_request && !timer_tick; endsequence
   property p_ready; s_setup |=> pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_rdata; !pready |-> prdata == 32'h00000000; endproperty
   property p_rst; disable iff (1'b0) rst |-> !pin_out && !irq_request && !pready; endproperty
   property p_dir; !$past(rst) |-> pin_out_enable == $past(pin_direction_bit); endproperty
   // interrupt may only rise after a tick or any register write
   property p_rise;
      $rose(irq_request) |-> $past(timer_tick, 2) || ($past(penable, 2) && $past(pwrite, 2));
   endproperty
   property p_svc; s_svc |=> ##1 !irq_request; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   a_err: assert property (p_err) else $error("error without ready");
   a_rdata: assert property (p_rdata) else $error("read data outside access");
   a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
   a_dir: assert property (p_dir) else $error("pin enable not following direction");
   a_rise: assert property (p_rise) else $error("interrupt rose without cause");
   a_svc: assert property (p_svc) else $error("interrupt not cleared by service");
endmodule // compare_unit_chk
bind timer_output_compare_unit compare_unit_chk u_compare_unit_chk (.clock(clock), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_tick(timer_tick), .irq_serviced(irq_serviced),
   .irq_request(irq_request), .pin_direction_bit(pin_direction_bit), .pin_out(pin_out),
   .pin_out_enable(pin_out_enable));
`default_nettype wire
